// ### logic/ctrd_regs.vh
/*
  constants for the core timer run/direction/toggle block: register byte
  offsets, control field positions, reset values, mode codes.
  assumes inclusion by bare name from design files of this block.
*/
`ifndef CTRD_REGS_VH
`define CTRD_REGS_VH
// How it works
// R1: with output enable set, the toggle output pin carries the overflow toggle latch.
// R2: with output enable clear, the toggle output pin is driven high.
// R3: external direction enable at bit 8 connects or disconnects the external direction pin.
// R4: the run bit at bit 6 starts and stops the core timer in every mode.
// R5: mode field bits 5..3 selects timer, counter, gated low, gated high, rotation and edge modes; 100 and 101 reserved.
// R6: input parameter field bits 2..0 is decoded per mode group.
// R7: in gated modes the timer counts only with run set and gate at its active level.
// R8: an auxiliary timer with remote control set is started and stopped by the core run bit.
// R9: direction is the software bit, or the software bit xor the external pin when enabled; 1 is down.
// R10: the direction status flag reads 0 for up and 1 for down.
// R11: direction may change at any time, running or not.
// R12: each overflow or underflow toggles the latch and the shadow follows it.
// R13: the shadow equals the latch delayed by one clock cycle.
// R14: a software write of the latch sets latch and shadow together, giving no trigger edge.
// R15: latch and shadow go to both auxiliary timers as trigger sources.
// R16: a software write of the count register wins over a hardware update in the same cycle.
// R17: overflow is ffff to 0000 counting up, underflow is 0000 to ffff counting down.
`define CTRD_OFF_CTRL 8'h00
`define CTRD_OFF_COUNT 8'h04
`define CTRD_OFF_AUX 8'h08
`define CTRD_OFF_STAT 8'h0C
`define CTRD_OFF_MASK 8'h10
`define CTRD_CTRL_RST 16'h0000
`define CTRD_COUNT_RST 16'h0000
`define CTRD_BIT_RDIR 15
`define CTRD_BIT_CHDIR 14
`define CTRD_BIT_EDGE 13
`define CTRD_BIT_OTL 10
`define CTRD_BIT_OE 9
`define CTRD_BIT_UDE 8
`define CTRD_BIT_UD 7
`define CTRD_BIT_RUN 6
`define CTRD_MODE_HI 5
`define CTRD_MODE_LO 3
`define CTRD_PAR_HI 2
`define CTRD_PAR_LO 0
`define CTRD_MODE_TIMER 3'h0
`define CTRD_MODE_COUNTER 3'h1
`define CTRD_MODE_GATE_LO 3'h2
`define CTRD_MODE_GATE_HI 3'h3
`define CTRD_MODE_ROT 3'h6
`define CTRD_MODE_EDGE 3'h7
`define CTRD_CTRL_WMASK 16'h07FF
`define CTRD_ST_OVF 0
`define CTRD_ST_UNF 1
`define CTRD_ST_DIR 2
`define CTRD_ST_EDGE 3
`define CTRD_ST_W 4
`endif

// ### logic/ctrd_toggle.v
/*
  overflow toggle latch with its one-cycle shadow.
  assumes one clock aclk and a synchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ctrd_toggle (
  input wire aclk,
  input wire aresetn,
  input wire wrap,
  input wire sw_we,
  input wire sw_val,
  output reg latch_q,
  output reg shadow_q
);
  // software write beats a wrap, and loads both so no edge appears
  always @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= 1'b0;
      shadow_q <= 1'b0;
    end else if (sw_we) begin
      latch_q <= sw_val; // [R14]
      shadow_q <= sw_val; // [R14]
    end else begin
      if (wrap) begin
        latch_q <= ~latch_q; // [R12]
      end
      shadow_q <= latch_q; // [R13]
    end
  end
endmodule
`default_nettype wire

// ### logic/ctrd_core.v
/*
  core timer control: control register, 16-bit count, run/gate/direction,
  counter and incremental input decode, toggle latch, aux triggers, irq.
  assumes an axi4-lite master on aclk; gate and direction pins are async
  and pass two flip-flops; count_tick is a prescaled enable from same domain.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ctrd_regs.vh"
module ctrd_core (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire count_tick,
  input wire timer_in_pin,
  input wire external_direction_pin,
  output wire toggle_output_pin,
  output wire toggle_latch_out,
  output wire toggle_shadow_out,
  output wire aux_a_run,
  output wire aux_b_run,
  output wire irq
);
  // control bits 15..10 are rebuilt on read from the flags and the toggle latch
  reg [15:0] ctrl_q;
  reg [15:0] count_q;
  reg [1:0] aux_rc_q;
  reg [`CTRD_ST_W-1:0] stat_q;
  reg [`CTRD_ST_W-1:0] mask_q;
  reg chdir_q;
  reg edgef_q;
  reg [1:0] tin_sync_q;
  reg [1:0] eud_sync_q;
  reg tin_prev_q;
  reg eud_prev_q;
  reg dir_prev_q;
  reg [7:0] awaddr_q;
  reg aw_full_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_full_q;
  wire tin;
  wire eud;
  wire [2:0] mode;
  wire [2:0] par;
  wire run;
  wire ude;
  wire dir_down;
  wire gate_ok;
  wire tin_rise;
  wire tin_fall;
  wire eud_rise;
  wire eud_fall;
  reg step;
  reg step_down;
  wire wrap;
  wire otl_q;
  wire do_write;
  wire do_read;
  wire wr_ctrl;
  wire wr_count;
  wire [7:0] wa;
  wire [31:0] wd;
  wire [3:0] ws;
  reg [31:0] rd;
  reg rd_ok;
  wire [`CTRD_ST_W-1:0] ev;

  // two-stage synchronisers; only the second stage is read
  always @(posedge aclk) begin
    if (!aresetn) begin
      tin_sync_q <= 2'b00;
      eud_sync_q <= 2'b00;
      tin_prev_q <= 1'b0;
      eud_prev_q <= 1'b0;
    end else begin
      tin_sync_q <= {tin_sync_q[0], timer_in_pin};
      eud_sync_q <= {eud_sync_q[0], external_direction_pin};
      tin_prev_q <= tin_sync_q[1];
      eud_prev_q <= eud_sync_q[1];
    end
  end
  assign tin = tin_sync_q[1];
  assign eud = eud_sync_q[1];
  assign tin_rise = tin & ~tin_prev_q;
  assign tin_fall = ~tin & tin_prev_q;
  assign eud_rise = eud & ~eud_prev_q;
  assign eud_fall = ~eud & eud_prev_q;

  // control fields
  assign mode = ctrl_q[`CTRD_MODE_HI:`CTRD_MODE_LO]; // [R5]
  assign par = ctrl_q[`CTRD_PAR_HI:`CTRD_PAR_LO];
  assign run = ctrl_q[`CTRD_BIT_RUN];
  assign ude = ctrl_q[`CTRD_BIT_UDE];
  // pin only matters when enabled; plain combinational so a change lands at once
  assign dir_down = ctrl_q[`CTRD_BIT_UD] ^ (ude & eud); // [R3] [R9] [R11]
  assign gate_ok = (mode == `CTRD_MODE_GATE_LO) ? ~tin : tin; // [R7]

  // per-mode count request; reserved modes and parameters never count
  always @* begin
    step = 1'b0;
    step_down = dir_down;
    case (mode) // [R5] [R6]
      // a tick held high counts on every cycle it stands
      `CTRD_MODE_TIMER: begin
        step = count_tick;
      end
      `CTRD_MODE_GATE_LO, `CTRD_MODE_GATE_HI: begin
        step = count_tick & gate_ok; // [R7]
      end
      `CTRD_MODE_COUNTER: begin
        // rising, falling or either edge of the synchronised input
        case (par)
          3'h1: step = tin_rise;
          3'h2: step = tin_fall;
          3'h3: step = tin_rise | tin_fall;
          default: step = 1'b0;
        endcase
      end
      `CTRD_MODE_ROT, `CTRD_MODE_EDGE: begin
        // quadrature: direction from edge versus level of the other input
        if ((par == 3'h1 || par == 3'h3) && (tin_rise || tin_fall)) begin
          step = 1'b1;
          step_down = (tin_rise ~^ eud) ^ ctrl_q[`CTRD_BIT_UD];
        end else if ((par == 3'h2 || par == 3'h3) && (eud_rise || eud_fall)) begin
          step = 1'b1;
          step_down = (eud_rise ^ tin) ^ ctrl_q[`CTRD_BIT_UD];
        end
      end
      default: step = 1'b0;
    endcase
    // run gates every mode last, so reserved codes stay stopped as well
    step = step & run; // [R4] [R7]
  end

  // wrap both ways of the 16-bit counter
  assign wrap = step & (step_down ? (count_q == 16'h0000) : (count_q == 16'hFFFF)); // [R17]

  // axi write: address and data latched in either order, then one response
  assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
  // a held channel wins; a live one only counts when taken this cycle
  assign wa = aw_full_q ? awaddr_q : s_axi_awaddr;
  assign wd = w_full_q ? wdata_q : s_axi_wdata;
  assign ws = w_full_q ? wstrb_q : s_axi_wstrb;
  assign do_write = (aw_full_q | (s_axi_awvalid & s_axi_awready)) &
                    (w_full_q | (s_axi_wvalid & s_axi_wready));
  assign wr_ctrl = do_write & (wa == `CTRD_OFF_CTRL);
  assign wr_count = do_write & (wa == `CTRD_OFF_COUNT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (do_write) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wa == `CTRD_OFF_CTRL || wa == `CTRD_OFF_COUNT || wa == `CTRD_OFF_AUX ||
                        wa == `CTRD_OFF_STAT || wa == `CTRD_OFF_MASK) ? 2'b00 : 2'b10;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_full_q <= 1'b1;
          awaddr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_full_q <= 1'b1;
          wdata_q <= s_axi_wdata;
          wstrb_q <= s_axi_wstrb;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // control, aux remote-control and mask registers; only low two lanes used
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CTRD_CTRL_RST;
      aux_rc_q <= 2'b00;
      mask_q <= {`CTRD_ST_W{1'b0}};
    end else if (do_write) begin
      if (wa == `CTRD_OFF_CTRL) begin
        if (ws[0]) ctrl_q[7:0] <= wd[7:0];
        // lane 1 also reloads the toggle pair; the latch bit itself lives there
        if (ws[1]) ctrl_q[9:8] <= wd[9:8];
      end
      if (wa == `CTRD_OFF_AUX && ws[0]) aux_rc_q <= wd[1:0];
      if (wa == `CTRD_OFF_MASK && ws[0]) mask_q <= wd[`CTRD_ST_W-1:0];
    end
  end

  // core count; a software write beats any same-cycle hardware step
  always @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `CTRD_COUNT_RST;
    end else if (wr_count) begin
      if (ws[0]) count_q[7:0] <= wd[7:0]; // [R16]
      if (ws[1]) count_q[15:8] <= wd[15:8]; // [R16]
    end else if (step) begin
      count_q <= step_down ? count_q - 16'h0001 : count_q + 16'h0001; // [R17]
    end
  end

  // toggle latch pair; software write of the latch bit loads both
  ctrd_toggle u_toggle (
    .aclk(aclk),
    .aresetn(aresetn),
    .wrap(wrap), // [R12]
    .sw_we(wr_ctrl & ws[1]), // [R14]
    .sw_val(wd[`CTRD_BIT_OTL]),
    .latch_q(otl_q),
    .shadow_q(toggle_shadow_out)
  );
  assign toggle_latch_out = otl_q; // [R15]
  // a disabled output idles high so external hardware sees no overflow
  assign toggle_output_pin = ctrl_q[`CTRD_BIT_OE] ? otl_q : 1'b1; // [R1] [R2]
  assign aux_a_run = aux_rc_q[0] & run; // [R8]
  assign aux_b_run = aux_rc_q[1] & run; // [R8]

  // hardware-set direction change and edge flags in the control word
  always @(posedge aclk) begin
    if (!aresetn) begin
      dir_prev_q <= 1'b0;
      chdir_q <= 1'b0;
      edgef_q <= 1'b0;
    end else begin
      dir_prev_q <= dir_down;
      if (dir_down != dir_prev_q) chdir_q <= 1'b1;
      else if (wr_ctrl & ws[1] & ~wd[`CTRD_BIT_CHDIR]) chdir_q <= 1'b0;
      if (step) edgef_q <= 1'b1;
      else if (wr_ctrl & ws[1] & ~wd[`CTRD_BIT_EDGE]) edgef_q <= 1'b0;
    end
  end

  // sticky events; set wins over the clear-on-read
  assign ev = {step, dir_down != dir_prev_q, wrap & step_down, wrap & ~step_down};
  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= {`CTRD_ST_W{1'b0}};
    end else if (do_read && s_axi_araddr == `CTRD_OFF_STAT) begin
      stat_q <= ev;
    end else begin
      stat_q <= stat_q | ev;
    end
  end
  assign irq = |(stat_q & mask_q);

  // axi read: one-cycle answer, held until rready
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_read = s_axi_arvalid & s_axi_arready;
  always @* begin
    rd = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CTRD_OFF_CTRL: rd[15:0] = {dir_down, chdir_q, edgef_q, 2'b00, otl_q, ctrl_q[9:0]}; // [R10]
      `CTRD_OFF_COUNT: rd[15:0] = count_q;
      `CTRD_OFF_AUX: rd[1:0] = aux_rc_q;
      `CTRD_OFF_STAT: rd[`CTRD_ST_W-1:0] = stat_q;
      `CTRD_OFF_MASK: rd[`CTRD_ST_W-1:0] = mask_q;
      default: rd_ok = 1'b0;
    endcase
  end
  // registered read data stands unchanged until rready is seen
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd;
      s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### verification/ctrd_core_sva.sv
/* checker on the ctrd_core ports: toggle pair, aux run, bus answers.
  assumes binding to every ctrd_core instance, one clock aclk. */
`timescale 1ns/100ps
`default_nettype none
module ctrd_core_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire toggle_output_pin,
  input wire toggle_latch_out,
  input wire toggle_shadow_out,
  input wire aux_a_run,
  input wire aux_b_run
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // pin low only when latch low; the enable is not a port of this checker
  pin_vs_latch_a: assert property (!toggle_output_pin |-> !toggle_latch_out)
    else $error("toggle pin low while latch high");
  // a hardware mismatch closes one cycle later, unless a write reloads the pair
  shadow_lag_a: assert property (toggle_latch_out != toggle_shadow_out
    && !(s_axi_awvalid && s_axi_awready) && !(s_axi_wvalid && s_axi_wready)
    |=> toggle_shadow_out == $past(toggle_latch_out)) else $error("shadow not one cycle behind");
  // both moving together only by a register write; either channel may come last
  sw_load_a: assert property ($changed(toggle_latch_out) && $changed(toggle_shadow_out)
    |-> $past(s_axi_awvalid) && $past(s_axi_awready) || $past(s_axi_wvalid) && $past(s_axi_wready))
    else $error("pair moved without a write");
  aux_a_run_a: assert property ($changed(aux_a_run)
    |-> $past(s_axi_awvalid) && $past(s_axi_awready) || $past(s_axi_wvalid) && $past(s_axi_wready))
    else $error("aux a run moved alone");
  aux_b_run_a: assert property ($changed(aux_b_run)
    |-> $past(s_axi_awvalid) && $past(s_axi_awready) || $past(s_axi_wvalid) && $past(s_axi_wready))
    else $error("aux b run moved alone");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after taken");
endmodule
bind ctrd_core ctrd_core_sva chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .toggle_output_pin, .toggle_latch_out, .toggle_shadow_out, .aux_a_run, .aux_b_run);
`default_nettype wire

// ### verification/ctrd_aux_model.sv
/* aux timer stand-in: counts trigger events of the toggle pair.
  assumes latch and shadow come straight from the core. */
`timescale 1ns/100ps
`default_nettype none
module ctrd_aux_model (
  input wire aclk,
  input wire aresetn,
  input wire latch,
  input wire shadow,
  output var int edges
);
  // any mismatch of the pair is one count event
  always @(posedge aclk) begin
    if (!aresetn) begin
      edges <= 0;
    end else if (latch !== shadow) begin
      edges <= edges + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/testbench.sv
/* self-checking bench for ctrd_core.
  assumes the aux model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic count_tick, timer_in_pin, external_direction_pin;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic toggle_output_pin, toggle_latch_out, toggle_shadow_out, aux_a_run, aux_b_run, irq;
  logic [31:0] d;
  logic [1:0] r, b;
  int fail_count, checks_done, edges, e;
  ctrd_core dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .count_tick, .timer_in_pin, .external_direction_pin, .toggle_output_pin,
    .toggle_latch_out, .toggle_shadow_out, .aux_a_run, .aux_b_run, .irq);
  ctrd_aux_model aux (.aclk, .aresetn, .latch(toggle_latch_out), .shadow(toggle_shadow_out), .edges);
  initial begin
    aclk = 0;
    forever #2 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // both write channels offered together; ready lines stay high
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    b = s_axi_bresp;
    if (n >= 50) chk(0, 1);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 50) chk(0, 1);
  endtask
  // trailing edge keeps two calls from driving the tick in one step
  task automatic ticks(input int k);
    count_tick <= 1'b1;
    repeat (k) @(posedge aclk);
    count_tick <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task t_dir;
    for (int i = 0; i < 8; i++) begin
      external_direction_pin <= i[2];
      wr(8'h00, {7'h00, i[1], i[0], i[0], 6'h00});
      repeat (4) @(posedge aclk);
      rd(8'h00);
      chk(d[15], i[0] ^ (i[1] & i[2]));
    end
    $display("direction test done");
  endtask
  task t_wrap;
    wr(8'h10, 16'h0003);
    wr(8'h04, 16'hffff);
    e = edges;
    wr(8'h00, 16'h0040);
    ticks(1);
    chk(toggle_latch_out, 1);
    chk(toggle_shadow_out, 1);
    chk(edges, e + 1);
    chk(irq, 1);
    rd(8'h04);
    chk(d, 0);
    rd(8'h0c);
    chk(d[1:0], 2'b01);
    chk(irq, 0);
    wr(8'h00, 16'h04c0);
    ticks(1);
    chk(toggle_latch_out, 0);
    chk(edges, e + 2);
    rd(8'h04);
    chk(d, 32'h0000_ffff);
    $display("wrap test done");
  endtask
  task t_out;
    e = edges;
    wr(8'h00, 16'h0600);
    chk({toggle_latch_out, toggle_shadow_out, toggle_output_pin}, 3'b111);
    wr(8'h00, 16'h0200);
    chk(toggle_output_pin, 0);
    chk(edges, e);
    wr(8'h00, 16'h0000);
    chk(toggle_output_pin, 1);
    $display("output test done");
  endtask
  task t_run;
    wr(8'h04, 16'h0005);
    chk(b, 2'b00);
    wr(8'h08, 16'h0001);
    ticks(3);
    rd(8'h04);
    chk(d, 5);
    wr(8'h00, 16'h0040);
    chk({aux_a_run, aux_b_run}, 2'b10);
    ticks(3);
    rd(8'h04);
    chk(d, 8);
    wr(8'h08, 16'h0002);
    chk({aux_a_run, aux_b_run}, 2'b01);
    wr(8'h00, 16'h0000);
    chk({aux_a_run, aux_b_run}, 2'b00);
    wr(8'h00, 16'h0058);
    ticks(2);
    rd(8'h04);
    chk(d, 8);
    // the gate input needs its two synchroniser stages before it counts
    timer_in_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    ticks(2);
    rd(8'h04);
    chk(d, 10);
    wr(8'h00, 16'h0060);
    ticks(2);
    rd(8'h04);
    chk(d, 10);
    // a count write on a ticking edge wins; the next edge adds one tick
    wr(8'h00, 16'h0040);
    count_tick <= 1'b1;
    wr(8'h04, 16'h1234);
    count_tick <= 1'b0;
    rd(8'h04);
    chk(d, 32'h0000_1235);
    rd(8'h14);
    chk(r, 2'b10);
    chk(d, 0);
    wr(8'h14, 16'h0000);
    chk(b, 2'b10);
    $display("run and bus test done");
  endtask
  // both pins move together and settle through the synchroniser and edge stage
  task automatic pins(input logic tin_v, input logic eud_v);
    timer_in_pin <= tin_v;
    external_direction_pin <= eud_v;
    repeat (4) @(posedge aclk);
  endtask
  // counter, gated-low and edge-detection modes from a known count
  task t_modes;
    pins(0, 0);
    wr(8'h04, 16'h0000);
    wr(8'h00, 16'h0049);
    pins(1, 0);
    pins(0, 0);
    pins(1, 0);
    rd(8'h04);
    chk(d, 2);
    wr(8'h00, 16'h0050);
    ticks(2);
    rd(8'h04);
    chk(d, 2);
    pins(0, 0);
    ticks(2);
    rd(8'h04);
    chk(d, 4);
    wr(8'h00, 16'h017b);
    pins(1, 0);
    pins(1, 1);
    pins(0, 1);
    pins(0, 0);
    rd(8'h04);
    chk(d, 8);
    pins(0, 1);
    rd(8'h04);
    chk(d, 7);
    $display("mode test done");
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #40000;
    fail_count++;
    print_verdict;
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, count_tick} = 0;
    {timer_in_pin, external_direction_pin, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(toggle_output_pin, 1);
    t_dir;
    t_wrap;
    t_out;
    t_run;
    t_modes;
    print_verdict;
  end
endmodule
`default_nettype wire
